// File: rtl/ctd_dispatch.sv
// threadgroup dispatcher: resource allocation, thread placement and payload writer
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ctd_dispatch
  import ctd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite register slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // threadgroup request from the walker
  input wire logic walk_valid,
  output logic walk_ready,
  input wire ctd_walk_t walk,
  // register payload toward the execution units
  output logic pay_valid,
  input wire logic pay_ready,
  output ctd_payload_t pay,
  // end of thread from the execution units
  input wire logic eot_valid,
  input wire ctd_eot_t eot
);
  typedef struct packed {
    ctd_state_t st;
    ctd_walk_t walk;
    logic [THR_W-1:0] thread;
    ctd_word_t word;
    logic [REG_IDX_W-1:0] reg_idx;
    logic [UNIT_W-1:0] unit;
    logic [TAG_W-1:0] slot;
    logic [NUM_UNITS-1:0][LOAD_W-1:0] load;
    logic [GROUP_SLOTS-1:0] slot_busy;
    logic [GROUP_SLOTS-1:0] slot_sending;
    logic [GROUP_SLOTS-1:0][THR_W-1:0] slot_live;
    logic ctrl_en;
    logic [31:0] groups;
    logic [7:0] live_total;
    logic aw_done;
    logic w_done;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctd_regs_t;

  ctd_regs_t r;
  ctd_regs_t next_r;

  logic fifo_in_ready;
  ctd_payload_t word_out;
  logic word_push;

  // payload buffer; a stalled unit side stops the word sequencer
  ctd_fifo #(
    .WIDTH($bits(ctd_payload_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(word_push),
    .in_ready(fifo_in_ready),
    .in_data(word_out),
    .out_valid(pay_valid),
    .out_ready(pay_ready),
    .out_data(pay)
  );

  // word that follows w for the current group's controls
  function automatic ctd_word_t after_word(ctd_word_t w, ctd_walk_t c, output logic done);
    ctd_word_t n;
    done = 1'b0;
    n = W_HDR;
    if (w == W_HDR && c.bindless)
      n = W_STK;
    else if ((w == W_HDR || w == W_STK) && c.emit_local)
      n = W_LX;
    else if (w == W_LX)
      n = W_LY;
    else if (w == W_LY)
      n = W_LZ;
    else if (w != W_INL && c.emit_inline)
      n = W_INL;
    else
      done = 1'b1;
    return n;
  endfunction : after_word

  // least-loaded unit with a free slot, and free capacity
  logic [UNIT_W-1:0] best_unit;
  logic [LOAD_W-1:0] best_load;
  logic [7:0] free_slots;
  logic [TAG_W-1:0] free_group;
  logic group_avail;

  always_comb
  begin
    best_unit = '0;
    best_load = LOAD_W'(UNIT_THREADS);
    free_slots = '0;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      free_slots = free_slots + 8'(UNIT_THREADS) - 8'(r.load[i]);
      if (r.load[i] < best_load)
      begin
        best_load = r.load[i];
        best_unit = UNIT_W'(i);
      end
    end
    free_group = '0;
    group_avail = 1'b0;
    for (int g = GROUP_SLOTS - 1; g >= 0; g--)
    begin
      if (!r.slot_busy[g])
      begin
        free_group = TAG_W'(g);
        group_avail = 1'b1;
      end
    end
  end

  // per-thread fields
  logic [15:0] lin;
  logic [15:0] loc_x;
  logic [15:0] loc_y;
  logic [15:0] loc_z;
  logic [SIMD-1:0] mask;
  logic last_thread;
  logic [63:0] hdr;

  always_comb
  begin
    lin = 16'(r.thread) << SIMD_LOG;
    loc_x = lin & ~(LANES_ALL << r.walk.log_x);
    loc_y = (lin >> r.walk.log_x) & ~(LANES_ALL << r.walk.log_y);
    loc_z = lin >> (r.walk.log_x + r.walk.log_y);
    last_thread = r.thread == r.walk.threads - 1'b1;
    mask = last_thread ? r.walk.last_mask : LANES_ALL[SIMD-1:0];
    // one layout for every thread; only mask and unit fields vary per thread
    hdr = '0;
    if (r.walk.indirect_len != '0)
      hdr[HDR_ADDR_LSB +: 32] = r.walk.indirect_addr;
    hdr[HDR_MASK_LSB +: SIMD] = mask;
    hdr[HDR_TAG_LSB +: TAG_W] = r.slot;
    hdr[HDR_BAR_VALID] = r.walk.barrier_req;
    hdr[HDR_BAR_LSB +: TAG_W] = r.walk.barrier_req ? r.slot : '0;
    if (r.walk.shm_req)
      hdr[HDR_SHM_LSB +: 8] = 8'(r.slot) << SHM_REGION_LOG;
  end

  always_comb
  begin
    word_out.unit = (r.word == W_HDR) ? best_unit : r.unit;
    word_out.reg_idx = r.reg_idx;
    word_out.first = r.word == W_HDR;
    word_out.last = seq_done;
    unique case (r.word)
      W_HDR: word_out.data = hdr;
      W_STK: word_out.data = 64'({r.slot, r.thread}) << SIMD_LOG;
      W_LX: word_out.data = 64'(loc_x);
      W_LY: word_out.data = 64'(loc_y);
      W_LZ: word_out.data = 64'(loc_z);
      W_INL: word_out.data = 64'(r.walk.inline_data);
      default: word_out.data = hdr;
    endcase
  end

  logic seq_done;
  ctd_word_t seq_next;
  logic can_start;

  always_comb
  begin
    seq_next = after_word(r.word, r.walk, seq_done);
    word_push = r.st == ST_SEND && fifo_in_ready;
    // group slot carries barrier id and memory region; capacity checked for all threads
    can_start = group_avail && r.ctrl_en && free_slots >= 8'(r.walk.threads);
    walk_ready = r.st == ST_IDLE;
  end

  // register access
  logic wr_fire;
  logic [31:0] rd_val;
  logic rd_err;

  always_comb
  begin
    wr_fire = r.aw_done && r.w_done && !r.bvalid;
    rd_err = 1'b0;
    rd_val = '0;
    unique case (s_axi_araddr)
      REG_CTRL: rd_val[CTRL_EN_BIT] = r.ctrl_en;
      REG_STATUS: rd_val = {16'(GROUP_SLOTS), 8'(r.st), 4'h0, r.slot_busy};
      REG_GROUPS: rd_val = r.groups;
      REG_LIVE: rd_val = {24'h0, r.live_total};
      default: rd_err = 1'b1;
    endcase
    s_axi_awready = !r.aw_done && !r.bvalid;
    s_axi_wready = !r.w_done && !r.bvalid;
    s_axi_arready = !r.rvalid;
    s_axi_bvalid = r.bvalid;
    s_axi_bresp = r.bresp;
    s_axi_rvalid = r.rvalid;
    s_axi_rdata = r.rdata;
    s_axi_rresp = r.rresp;
  end

  always_comb
  begin
    next_r = r;
    // bus side
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_done = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_done = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_r.aw_done = 1'b0;
      next_r.w_done = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.awaddr == REG_CTRL)
      begin
        if (r.wstrb[0])
          next_r.ctrl_en = r.wdata[CTRL_EN_BIT];
      end
      else if (r.awaddr != REG_STATUS && r.awaddr != REG_GROUPS && r.awaddr != REG_LIVE)
        next_r.bresp = RESP_SLVERR;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_val;
      next_r.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    if (r.rvalid && s_axi_rready)
      next_r.rvalid = 1'b0;
    // end of thread returns unit slot and group count
    if (eot_valid)
    begin
      next_r.load[eot.unit] = r.load[eot.unit] - 1'b1;
      next_r.slot_live[eot.tag] = r.slot_live[eot.tag] - 1'b1;
      next_r.live_total = r.live_total - 1'b1;
    end

    // dispatch sequencer
    unique case (r.st)
      ST_IDLE:
      begin
        if (walk_valid && walk.threads != '0)
        begin
          next_r.walk = walk;
          next_r.st = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (can_start)
        begin
          // allocation at group start; live count covers all threads
          next_r.slot = free_group;
          next_r.slot_busy[free_group] = 1'b1;
          next_r.slot_sending[free_group] = 1'b1;
          next_r.slot_live[free_group] = next_r.slot_live[free_group] + r.walk.threads;
          next_r.groups = r.groups + 1'b1;
          next_r.thread = '0;
          next_r.word = W_HDR;
          next_r.reg_idx = '0;
          next_r.st = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (word_push)
        begin
          if (r.word == W_HDR)
          begin
            // placement chosen as the thread starts; capacity was checked at group start, so a unit is free
            next_r.unit = best_unit;
            next_r.load[best_unit] = next_r.load[best_unit] + 1'b1;
            next_r.live_total = next_r.live_total + 1'b1;
          end
          next_r.reg_idx = r.reg_idx + 1'b1;
          next_r.word = seq_next;
          if (seq_done)
          begin
            next_r.word = W_HDR;
            next_r.reg_idx = '0;
            next_r.thread = r.thread + 1'b1;
            if (last_thread)
            begin
              next_r.slot_sending[r.slot] = 1'b0;
              next_r.st = ST_IDLE;
            end
          end
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // slot, barrier id and memory region return after the last thread ends
    for (int g = 0; g < GROUP_SLOTS; g++)
    begin
      if (r.slot_busy[g] && !next_r.slot_sending[g] && next_r.slot_live[g] == '0)
        next_r.slot_busy[g] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.word <= W_HDR;
      r.ctrl_en <= CTRL_EN_RESET;
    end
    else
      r <= next_r;
  end
endmodule : ctd_dispatch

// File: rtl/ctd_pkg.sv
// shared constants and carrier types of the compute thread dispatcher
package ctd_pkg;
  localparam int NUM_UNITS = 8;
  localparam int UNIT_THREADS = 7;
  localparam int UNIT_W = 3;
  localparam int LOAD_W = 4;
  localparam int GROUP_SLOTS = 4;
  localparam int TAG_W = 2;
  localparam int THR_W = 6;
  localparam int SIMD_LOG = 4;
  localparam int SIMD = 16;
  localparam int REG_IDX_W = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int SHM_REGION_LOG = 4;

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_GROUPS = 8'h08;
  localparam logic [7:0] REG_LIVE = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // header register field positions
  localparam int HDR_ADDR_LSB = 32;
  localparam int HDR_MASK_LSB = 16;
  localparam int HDR_TAG_LSB = 12;
  localparam int HDR_BAR_VALID = 11;
  localparam int HDR_BAR_LSB = 8;
  localparam int HDR_SHM_LSB = 0;

  localparam logic [15:0] LANES_ALL = 16'hFFFF;

  typedef struct packed {
    logic [THR_W-1:0] threads;
    logic [SIMD-1:0] last_mask;
    logic bindless;
    logic emit_local;
    logic emit_inline;
    logic barrier_req;
    logic shm_req;
    logic [15:0] indirect_len;
    logic [31:0] indirect_addr;
    logic [31:0] inline_data;
    logic [3:0] log_x;
    logic [3:0] log_y;
  } ctd_walk_t;

  typedef struct packed {
    logic [UNIT_W-1:0] unit;
    logic [REG_IDX_W-1:0] reg_idx;
    logic first;
    logic last;
    logic [63:0] data;
  } ctd_payload_t;

  typedef struct packed {
    logic [UNIT_W-1:0] unit;
    logic [TAG_W-1:0] tag;
  } ctd_eot_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND} ctd_state_t;
  typedef enum logic [2:0] {W_HDR, W_STK, W_LX, W_LY, W_LZ, W_INL} ctd_word_t;
endpackage : ctd_pkg

// File: rtl/ctd_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module ctd_fifo
  import ctd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != DEPTH_CNT;
  assign out_valid = count != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset; empty flag guards the output
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end
endmodule : ctd_fifo

// File: rtl/ctd_dispatch_fix_note.sv
// spare design file: all logic sits in the dispatcher and its fifo

// File: bench/ctd_dispatch_assertions.sv
// concurrent checks on the dispatcher ports
`timescale 1ns/1ps
module ctd_dispatch_assertions
  import ctd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // walker, payload and end of thread
  input wire logic walk_valid,
  input wire logic walk_ready,
  input wire ctd_walk_t walk,
  input wire logic pay_valid,
  input wire logic pay_ready,
  input wire ctd_payload_t pay,
  input wire logic eot_valid,
  input wire ctd_eot_t eot
);
  // register index the next beat must carry; restarts after each thread's last beat
  logic [REG_IDX_W-1:0] want_idx;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      want_idx <= '0;
    else if (pay_valid && pay_ready)
      want_idx <= pay.last ? '0 : pay.reg_idx + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_reg_order: assert property (pay_valid |-> pay.reg_idx == want_idx && pay.first == (want_idx == 0))
    else $error("payload register out of order");
  a_pay_hold: assert property (pay_valid && !pay_ready |=> pay_valid && $stable(pay))
    else $error("payload changed while stalled");
  a_bar_id: assert property (pay_valid && pay.first && pay.data[HDR_BAR_VALID]
    |-> pay.data[9:8] == pay.data[13:12])
    else $error("barrier id differs from group");
  a_shared_base: assert property (pay_valid && pay.first && pay.data[7:0] != 8'h00
    |-> pay.data[7:0] == {2'h0, pay.data[13:12], 4'h0})
    else $error("shared memory base wrong");
  a_walk_one: assert property (walk_valid && walk_ready && walk.threads != 0 |=> !walk_ready)
    else $error("second group taken");
  a_bresp_due: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_due: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : ctd_dispatch_assertions

bind ctd_dispatch ctd_dispatch_assertions i_chk (.*);

// File: bench/ctd_eu_model.sv
// execution unit side: takes payload beats, returns end of thread on demand
`timescale 1ns/1ps
module ctd_unit_model
  import ctd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench controls
  input wire logic stall,
  input wire logic release_eot,
  // payload
  input wire logic pay_valid,
  output logic pay_ready,
  input wire ctd_payload_t pay,
  // end of thread
  output logic eot_valid,
  output ctd_eot_t eot
);
  ctd_payload_t got[$];
  ctd_eot_t live[$];
  logic [TAG_W-1:0] hdr_tag;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pay_ready <= 1'b0;
      eot_valid <= 1'b0;
      eot <= '0;
    end
    else
    begin
      pay_ready <= !stall;
      if (pay_valid && pay_ready)
      begin
        got.push_back(pay);
        if (pay.first)
          hdr_tag = pay.data[13:12];
        if (pay.last)
          live.push_back({pay.unit, pay.first ? pay.data[13:12] : hdr_tag});
      end
      eot_valid <= release_eot && live.size() > 0;
      // idle eot fields toggle so a stale value is never mistaken for a fresh one
      eot <= (release_eot && live.size() > 0) ? live.pop_front() : ~eot;
    end
  end
endmodule : ctd_unit_model

// File: bench/ctd_dispatch_tb.sv
// dispatcher bench: registers, payload layout, group holds
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ctd_dispatch_tb
  import ctd_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic walk_valid = 1'b0;
  logic walk_ready, pay_valid, pay_ready, eot_valid;
  logic stall = 1'b0;
  logic release_eot = 1'b1;
  ctd_walk_t walk = '0;
  ctd_payload_t pay;
  ctd_eot_t eot;
  int mismatches = 0;
  int checked = 0;

  always #4 clk = ~clk;
  ctd_dispatch i_dut (.*);
  ctd_unit_model i_units (.*);

  task automatic summarize();
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // readies are sampled mid-cycle, where they stay settled until the taking edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh;
    logic bh = 1'b0;
    logic [1:0] r = 2'h3;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40 && !bh; i++)
    begin
      @(negedge clk);
      ah = s_axi_awready;
      wh = s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ah)
        s_axi_awvalid <= 1'b0;
      if (wh)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, r)
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah;
    logic rh = 1'b0;
    logic [31:0] d;
    logic [1:0] r = 2'h3;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40 && !rh; i++)
    begin
      @(negedge clk);
      ah = s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ah)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, r)
    if (er == RESP_OKAY)
      `CHK("rdata", ed, d)
  endtask : axr

  task automatic walk_go(input ctd_walk_t w);
    logic ok = 1'b0;
    @(posedge clk);
    walk_valid <= 1'b1;
    walk <= w;
    for (int i = 0; i < 60 && !ok; i++)
    begin
      @(negedge clk);
      ok = walk_ready;
      @(posedge clk);
    end
    walk_valid <= 1'b0;
    `CHK("walk taken", 1'b1, ok)
  endtask : walk_go

  task automatic wait_got(input int n);
    for (int i = 0; i < 400 && i_units.got.size() < n; i++)
      @(posedge clk);
    `CHK("beats", n, i_units.got.size())
  endtask : wait_got

  task automatic chk_hdr(input ctd_payload_t p, input int t, input int n, input ctd_walk_t w);
    `CHK("first", 1'b1, p.first)
    `CHK("mask", (t == n - 1) ? w.last_mask : LANES_ALL, p.data[31:16])
    `CHK("addr", (w.indirect_len != 0) ? w.indirect_addr : 32'h0, p.data[63:32])
    `CHK("barrier", w.barrier_req, p.data[HDR_BAR_VALID])
    `CHK("shared", w.shm_req ? {2'h0, p.data[13:12], 4'h0} : 8'h00, p.data[7:0])
  endtask : chk_hdr

  function automatic logic [63:0] lid(input int t, input int k, input ctd_walk_t w);
    int i = t * SIMD;
    if (k == 2)
      return 64'(i & ((1 << w.log_x) - 1));
    if (k == 3)
      return 64'((i >> w.log_x) & ((1 << w.log_y) - 1));
    return 64'(i >> (w.log_x + w.log_y));
  endfunction : lid

  task automatic t_regs();
    axr(REG_CTRL, 32'h1, RESP_OKAY);
    axr(REG_STATUS, 32'h0004_0000, RESP_OKAY);
    axw(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    axr(REG_STATUS, 32'h0004_0000, RESP_OKAY);
    axr(8'h40, 32'h0, RESP_SLVERR);
    axw(8'h40, 32'h0, RESP_SLVERR);
    axw(REG_CTRL, 32'h0, RESP_OKAY);
    axr(REG_CTRL, 32'h0, RESP_OKAY);
  endtask : t_regs

  // enable is off on entry; units keep their threads so placement is visible
  task automatic t_plain();
    ctd_walk_t w = '{threads: 6'd2, last_mask: 16'h00F3, indirect_addr: 32'h8000_0100, default: '0};
    i_units.got.delete();
    release_eot <= 1'b0;
    walk_go(w);
    repeat (20) @(posedge clk);
    `CHK("held", 0, i_units.got.size())
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    wait_got(2);
    for (int t = 0; t < 2; t++)
    begin
      chk_hdr(i_units.got[t], t, 2, w);
      `CHK("unit", 3'(t), i_units.got[t].unit)
      `CHK("only", 1'b1, i_units.got[t].last)
    end
    release_eot <= 1'b1;
  endtask : t_plain

  task automatic t_full();
    ctd_walk_t w = '{threads: 6'd3, last_mask: 16'h7FFF, indirect_len: 16'h0040, indirect_addr: 32'hC0DE_0A00,
      inline_data: 32'h1234_5678, log_x: 4'h4, log_y: 4'h1, default: 1'b1};
    ctd_payload_t q;
    logic [1:0] tag0;
    i_units.got.delete();
    stall <= 1'b1;
    walk_go(w);
    repeat (30) @(posedge clk);
    @(negedge clk);
    `CHK("stalled", 0, i_units.got.size())
    `CHK("walk busy", 1'b0, walk_ready)
    stall <= 1'b0;
    wait_got(18);
    @(negedge clk);
    `CHK("drained", 1'b0, pay_valid)
    tag0 = i_units.got[0].data[13:12];
    for (int t = 0; t < 3; t++)
    begin
      chk_hdr(i_units.got[t * 6], t, 3, w);
      `CHK("tag", tag0, i_units.got[t * 6].data[13:12])
      for (int k = 1; k < 6; k++)
      begin
        q = i_units.got[t * 6 + k];
        `CHK("last", k == 5, q.last)
        if (k == 1)
          `CHK("stack", {tag0, 6'(t), 4'h0}, q.data)
        else if (k == 5)
          `CHK("inline", w.inline_data, q.data)
        else
          `CHK("local", lid(t, k, w), q.data)
      end
    end
  endtask : t_full

  task automatic t_slots();
    ctd_walk_t w = '{threads: 6'd1, last_mask: 16'h0001, barrier_req: 1'b1, default: '0};
    logic [3:0] seen = 4'h0;
    i_units.got.delete();
    release_eot <= 1'b0;
    for (int g = 0; g < 5; g++)
      walk_go(w);
    repeat (40) @(posedge clk);
    `CHK("held", 4, i_units.got.size())
    for (int g = 0; g < 4; g++)
      seen[i_units.got[g].data[13:12]] = 1'b1;
    `CHK("ids", 4'hF, seen)
    axr(REG_LIVE, 32'h4, RESP_OKAY);
    release_eot <= 1'b1;
    wait_got(5);
    repeat (20) @(posedge clk);
    axr(REG_LIVE, 32'h0, RESP_OKAY);
    axr(REG_GROUPS, 32'h7, RESP_OKAY);
  endtask : t_slots

  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_plain();
    t_full();
    t_slots();
    summarize();
  end

  // the whole sequence needs a few hundred cycles; this leaves ample margin
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule : ctd_dispatch_tb
